// ==== pkg/aocp_defines.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the converter control.
// Assumes: Byte addressing on the register bus, one 32-bit word per register.
// Notes: Timing counts are in input-clock cycles unless named otherwise.
`ifndef AOCP_DEFINES_SVH
`define AOCP_DEFINES_SVH

// Register byte offsets.
`define AOCP_ADDR_CTRL 4'h0
`define AOCP_ADDR_STATUS 4'h4
`define AOCP_ADDR_PHASE 4'h8

// Control register field positions.
`define AOCP_CTRL_DES 0
`define AOCP_CTRL_SEL_Q 1
`define AOCP_CTRL_BG 2
`define AOCP_CTRL_DDR 3
`define AOCP_CTRL_EDGE 4
`define AOCP_CTRL_SWING 5
`define AOCP_CTRL_DCC 6
`define AOCP_CTRL_RESET 7'h6C

// Status register field positions.
`define AOCP_STAT_TRIM 0
`define AOCP_STAT_PD 1
`define AOCP_STAT_PEND 2
`define AOCP_STAT_VALID 3
`define AOCP_STAT_QUNCAL 4
`define AOCP_STAT_QDOWN 5
`define AOCP_STAT_FSM_LO 8

// Pipeline latencies and refill length, in input-clock cycles.
`define AOCP_LAT_CUR 13
`define AOCP_LAT_DEL 14
`define AOCP_FILL_CYC 5'h0F

// Defaults of the long counts, in input-clock cycles.
`define AOCP_PU_DELAY_CYC 16'h0400
`define AOCP_CAL_CYC 16'h0800
`define AOCP_TRIM_LOW_MIN 8'h08
`define AOCP_TRIM_HIGH_MIN 8'h08

`endif

// ==== pkg/aocp_pkg.sv ====
// Purpose: Types shared by the converter control and its bench.
// Assumes: Offsets and counts live in aocp_defines.svh.
// Notes: State machine codes are one-hot.
package aocp_pkg;

   typedef enum logic [4:0] {
      ST_POWERON = 5'h01,
      ST_PUDLY = 5'h02,
      ST_CAL = 5'h04,
      ST_RUN = 5'h08,
      ST_PDOWN = 5'h10
   } aocp_fsm_t;

   // The four output buses presented together.
   typedef struct packed {
      logic [7:0] q_del;
      logic [7:0] i_del;
      logic [7:0] q_cur;
      logic [7:0] i_cur;
   } aocp_bus_t;

   // Pins from outside the clock domain.
   typedef struct packed {
      logic conv_clk;
      logic [7:0] i_in;
      logic [7:0] q_in;
      logic pd;
      logic qpd;
      logic trim_req;
      logic edge_sel;
      logic edge_float;
      logic swing;
      logic des;
      logic ext;
   } aocp_pins_t;

   typedef struct packed {
      logic dcc;
      logic swing;
      logic edge_sel;
      logic ddr;
      logic bg;
      logic sel_q;
      logic des;
   } aocp_ctrl_t;

   typedef struct packed {
      aocp_pins_t s1;
      aocp_pins_t s2;
      logic clk_prev;
      logic [7:0] per_cnt;
      logic [7:0] per_len;
      logic fall_armed;
      logic ext_mode;
      logic ext_taken;
      aocp_ctrl_t ctrl;
      aocp_fsm_t fsm;
      logic pd_pending;
      logic q_uncal;
      logic [15:0] cnt;
      logic [7:0] low_cnt;
      logic [7:0] high_cnt;
      logic [4:0] fill_cnt;
      logic word_phase;
      logic [13:0][7:0] ihist;
      logic [13:0][7:0] qhist;
      logic [14:0][7:0] rhist;
      aocp_bus_t bus;
      logic oclk;
      logic oor;
      logic valid;
      logic [5:0] phase_trim;
      logic ack;
      logic [31:0] rdata;
   } aocp_state_t;

endpackage : aocp_pkg

// ==== core/aocp_core.sv ====
// Purpose: Output clocking, dual-edge sampling and power/calibration control of a dual converter.
// Assumes: The input clock is far slower than clk and is found by sampling it.
// Notes: Counts are in input-clock cycles; registers sit on Avalon-MM with waitrequest.
//
// Local design decisions: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
`include "aocp_defines.svh"

module aocp_core #(
   parameter logic [15:0] PU_DELAY_CYC = `AOCP_PU_DELAY_CYC,
   parameter logic [15:0] CAL_CYC = `AOCP_CAL_CYC,
   parameter logic [7:0] TRIM_LOW_MIN = `AOCP_TRIM_LOW_MIN,
   parameter logic [7:0] TRIM_HIGH_MIN = `AOCP_TRIM_HIGH_MIN
) (
   // Clock, reset, enable.
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Avalon-MM slave.
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Converter pins.
   input wire logic conv_clk,
   input wire logic [7:0] i_in,
   input wire logic [7:0] q_in,
   input wire logic power_down_pin,
   input wire logic q_channel_power_down,
   input wire logic trim_request,
   input wire logic output_edge_select,
   input wire logic output_edge_floating,
   input wire logic output_swing_select,
   input wire logic des_select,
   input wire logic ext_control_enable,
   // Output side.
   output aocp_pkg::aocp_bus_t data_bus,
   output logic data_oe,
   output logic output_data_clock,
   output logic out_of_range_flag,
   output logic output_drive_full,
   output logic trim_running,
   output logic data_valid,
   output logic q_converter_active
);
   import aocp_pkg::*;

   aocp_state_t st;
   aocp_state_t nx;
   aocp_pins_t pins_raw;

   logic rise_ev;
   logic fall_ev;
   logic ext_now;
   logic des_on;
   logic sel_q;
   logic ddr_on;
   logic edge_hi;
   logic dcc_on;
   logic bg_on;
   logic trim_done;
   logic [7:0] sel_smp;
   logic [7:0] q_smp;

   function automatic logic [7:0] sat_inc8(input logic [7:0] v);
      sat_inc8 = (v == 8'hFF) ? v : v + 8'h01;
   endfunction : sat_inc8

   function automatic logic is_rail(input logic [7:0] v);
      is_rail = (v == 8'h00) || (v == 8'hFF);
   endfunction : is_rail

   assign pins_raw = '{conv_clk: conv_clk, i_in: i_in, q_in: q_in, pd: power_down_pin,
                       qpd: q_channel_power_down, trim_req: trim_request,
                       edge_sel: output_edge_select, edge_float: output_edge_floating,
                       swing: output_swing_select, des: des_select,
                       ext: ext_control_enable};

   always_comb begin
      nx = st;
      // Pins cross into clk through two flops; only s2 is read by logic.
      nx.s1 = pins_raw;
      nx.s2 = st.s1;
      nx.clk_prev = st.s2.conv_clk;
      rise_ev = st.s2.conv_clk & ~st.clk_prev;
      ext_now = st.ext_taken & st.ext_mode;
      des_on = ext_now ? st.ctrl.des : st.s2.des;
      sel_q = ext_now & st.ctrl.sel_q;
      ddr_on = ext_now ? st.ctrl.ddr : st.s2.edge_float;
      edge_hi = ext_now ? st.ctrl.edge_sel : st.s2.edge_sel;
      dcc_on = ext_now ? st.ctrl.dcc : 1'b1;
      bg_on = ext_now ? st.ctrl.bg : 1'b1;
      // Duty-cycle correction places the falling edge at half the measured period,
      // so a lopsided input clock still yields evenly spaced sampling instants.
      if (dcc_on) begin
         fall_ev = st.fall_armed && (st.per_cnt == {1'b0, st.per_len[7:1]});
      end else begin
         fall_ev = ~st.s2.conv_clk & st.clk_prev;
      end
      nx.per_cnt = rise_ev ? 8'h00 : sat_inc8(st.per_cnt);
      if (rise_ev) begin
         nx.per_len = sat_inc8(st.per_cnt);
         nx.fall_armed = 1'b1;
      end else if (fall_ev) begin
         nx.fall_armed = 1'b0;
      end
      // Extended-control strap is caught once after reset release.
      if (!st.ext_taken) begin
         nx.ext_taken = 1'b1;
         nx.ext_mode = st.s2.ext;
      end
      sel_smp = sel_q ? st.s2.q_in : st.s2.i_in;
      q_smp = st.s2.qpd ? 8'h00 : st.s2.q_in;

      // On-command request: low for a minimum, then high for a minimum.
      trim_done = 1'b0;
      if (rise_ev) begin
         if (!st.s2.trim_req) begin
            nx.low_cnt = sat_inc8(st.low_cnt);
            nx.high_cnt = 8'h00;
         end else if (st.low_cnt >= TRIM_LOW_MIN) begin
            nx.high_cnt = sat_inc8(st.high_cnt);
            if (sat_inc8(st.high_cnt) >= TRIM_HIGH_MIN) begin
               trim_done = 1'b1;
               nx.low_cnt = 8'h00;
               nx.high_cnt = 8'h00;
            end
         end else begin
            nx.high_cnt = 8'h00;
         end
      end

      // Single control machine; power-down during calibration is deferred.
      case (st.fsm)
         ST_POWERON: begin
            if (!st.s2.pd) begin
               nx.fsm = ST_PUDLY;
               nx.cnt = 16'h0000;
            end
         end
         ST_PUDLY: begin
            if (st.s2.pd) begin
               nx.fsm = ST_POWERON;
            end else if (rise_ev) begin
               nx.cnt = st.cnt + 16'h0001;
               if (st.cnt + 16'h0001 >= PU_DELAY_CYC) begin
                  nx.fsm = ST_CAL;
                  nx.cnt = 16'h0000;
               end
            end
         end
         ST_CAL: begin
            if (st.s2.pd) begin
               nx.pd_pending = 1'b1;
            end
            if (rise_ev) begin
               nx.cnt = st.cnt + 16'h0001;
               if (st.cnt + 16'h0001 >= CAL_CYC) begin
                  nx.q_uncal = st.s2.qpd;
                  nx.pd_pending = 1'b0;
                  nx.fill_cnt = 5'h00;
                  nx.fsm = (st.pd_pending || st.s2.pd) ? ST_PDOWN : ST_RUN;
               end
            end
         end
         ST_RUN: begin
            if (st.s2.pd) begin
               nx.fsm = ST_PDOWN;
            end else if (trim_done) begin
               nx.fsm = ST_CAL;
               nx.cnt = 16'h0000;
            end
         end
         ST_PDOWN: begin
            // A request seen while powered down is wiped, never replayed.
            nx.low_cnt = 8'h00;
            nx.high_cnt = 8'h00;
            if (!st.s2.pd) begin
               nx.fsm = ST_RUN;
               nx.fill_cnt = 5'h00;
            end
         end
         default: begin
            nx.fsm = ST_POWERON;
         end
      endcase

      // Q converter samples the selected input on the rise in dual-edge mode.
      if (rise_ev && des_on) begin
         nx.rhist = {st.rhist[13:0], q_smp == 8'h00 && st.s2.qpd ? 8'h00 : sel_smp};
      end

      if (fall_ev && st.fsm != ST_CAL && st.fsm != ST_PDOWN && st.fsm != ST_POWERON) begin
         nx.ihist = {st.ihist[12:0], des_on ? sel_smp : st.s2.i_in};
         nx.qhist = {st.qhist[12:0], q_smp};
         nx.word_phase = ~st.word_phase;
         if (st.fill_cnt != `AOCP_FILL_CYC) begin
            nx.fill_cnt = st.fill_cnt + 5'h01;
         end
         // Background phase trim nudges toward equal rise and fall codes.
         if (des_on && bg_on && !st.s2.qpd) begin
            if (sel_smp > st.rhist[0] && st.phase_trim != 6'h3F) begin
               nx.phase_trim = st.phase_trim + 6'h01;
            end else if (sel_smp < st.rhist[0] && st.phase_trim != 6'h00) begin
               nx.phase_trim = st.phase_trim - 6'h01;
            end
         end
         if (st.word_phase) begin
            // Pre-shift index k-1 holds the sample taken k falls ago.
            nx.bus.i_cur = st.ihist[`AOCP_LAT_CUR - 1];
            nx.bus.i_del = st.ihist[`AOCP_LAT_DEL - 1];
            if (des_on) begin
               nx.bus.q_cur = st.rhist[`AOCP_LAT_CUR];
               nx.bus.q_del = st.rhist[`AOCP_LAT_DEL];
            end else begin
               nx.bus.q_cur = st.qhist[`AOCP_LAT_CUR - 1];
               nx.bus.q_del = st.qhist[`AOCP_LAT_DEL - 1];
            end
            nx.oor = is_rail(st.ihist[`AOCP_LAT_CUR - 1]) | is_rail(st.ihist[`AOCP_LAT_DEL - 1]);
            nx.valid = (st.fill_cnt == `AOCP_FILL_CYC) && st.fsm == ST_RUN;
            nx.oclk = ddr_on ? ~st.oclk : edge_hi;
         end else if (!ddr_on) begin
            nx.oclk = ~edge_hi;
         end
      end
      if (st.fsm == ST_PDOWN || st.fsm == ST_POWERON) begin
         nx.oclk = 1'b0;
         nx.oor = 1'b0;
         nx.valid = 1'b0;
      end
      if (st.fsm == ST_CAL) begin
         nx.valid = 1'b0;
      end

      // Bus slave: one wait cycle, then the access completes.
      nx.ack = (avs_read | avs_write) & ~st.ack;
      if ((avs_read | avs_write) && !st.ack) begin
         case (avs_address)
            `AOCP_ADDR_CTRL: nx.rdata = {25'h000_0000, st.ctrl};
            `AOCP_ADDR_STATUS: begin
               nx.rdata = 32'h0000_0000;
               nx.rdata[`AOCP_STAT_TRIM] = st.fsm == ST_CAL;
               nx.rdata[`AOCP_STAT_PD] = st.fsm == ST_PDOWN || st.fsm == ST_POWERON;
               nx.rdata[`AOCP_STAT_PEND] = st.pd_pending;
               nx.rdata[`AOCP_STAT_VALID] = st.valid;
               nx.rdata[`AOCP_STAT_QUNCAL] = st.q_uncal;
               nx.rdata[`AOCP_STAT_QDOWN] = st.s2.qpd;
               nx.rdata[`AOCP_STAT_FSM_LO +: 5] = st.fsm;
            end
            `AOCP_ADDR_PHASE: nx.rdata = {26'h000_0000, st.phase_trim};
            default: nx.rdata = 32'h0000_0000;
         endcase
      end
      if (avs_write && st.ack && avs_address == `AOCP_ADDR_CTRL) begin
         nx.ctrl = avs_writedata[6:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
         st.fsm <= ST_POWERON;
         st.ctrl <= `AOCP_CTRL_RESET;
         // Synchronisers keep running in reset, so the strap caught at the first edge
         // after release is the real pin and no false input-clock edge follows release.
         st.s1 <= pins_raw;
         st.s2 <= st.s1;
         st.clk_prev <= st.s2.conv_clk;
      end else if (ce) begin
         st <= nx;
      end
   end

   assign avs_waitrequest = (avs_read | avs_write) & ~st.ack;
   assign avs_readdata = st.rdata;
   assign data_bus = st.bus;
   assign data_oe = ~(st.fsm == ST_PDOWN || st.fsm == ST_POWERON);
   assign output_data_clock = st.oclk;
   assign out_of_range_flag = st.oor;
   assign output_drive_full = st.ext_mode ? st.ctrl.swing : st.s2.swing;
   assign trim_running = st.fsm == ST_CAL;
   assign data_valid = st.valid;
   assign q_converter_active = ~st.s2.qpd & data_oe;

   property p_pd_enter;
      @(posedge clk) disable iff (reset)
      (ce && st.fsm == ST_RUN && st.s2.pd) |=> (st.fsm == ST_PDOWN);
   endproperty
   a_pd_enter: assert property (p_pd_enter) else $error("power-down not entered");

   property p_pd_pins;
      @(posedge clk) disable iff (reset)
      (st.fsm == ST_PDOWN) |=> (!data_oe && !output_data_clock && !out_of_range_flag)
         or (st.fsm != ST_PDOWN);
   endproperty
   a_pd_pins: assert property (p_pd_pins) else $error("outputs active in power-down");

   property p_cal_defer;
      @(posedge clk) disable iff (reset)
      (ce && st.fsm == ST_CAL && st.s2.pd && !rise_ev) |=> (st.fsm == ST_CAL && st.pd_pending);
   endproperty
   a_cal_defer: assert property (p_cal_defer) else $error("calibration cut short");

   property p_hold_poweron;
      @(posedge clk) disable iff (reset)
      (ce && st.fsm == ST_POWERON && st.s2.pd) |=> (st.fsm == ST_POWERON && !trim_running);
   endproperty
   a_hold_poweron: assert property (p_hold_poweron) else $error("early power-up trim");

   property p_pd_no_cal;
      @(posedge clk) disable iff (reset)
      (st.fsm == ST_PDOWN) |=> (st.fsm != ST_CAL);
   endproperty
   a_pd_no_cal: assert property (p_pd_no_cal) else $error("trim started in power-down");

   property p_refill;
      @(posedge clk) disable iff (reset)
      ($past(st.fsm) == ST_PDOWN && st.fsm == ST_RUN) |-> !data_valid ##1 !data_valid;
   endproperty
   a_refill: assert property (p_refill) else $error("stale pipeline marked valid");

   property p_trim_flag;
      @(posedge clk) disable iff (reset)
      $rose(trim_running) |-> ($past(st.fsm) == ST_PUDLY || $past(st.fsm) == ST_RUN);
   endproperty
   a_trim_flag: assert property (p_trim_flag) else $error("trim flag rose without cause");

   property p_q_uncal;
      @(posedge clk) disable iff (reset)
      ($fell(trim_running) && $past(st.s2.qpd)) |-> st.q_uncal;
   endproperty
   a_q_uncal: assert property (p_q_uncal) else $error("Q marked calibrated");

   property p_sdr_edge;
      @(posedge clk) disable iff (reset)
      ($changed(st.bus) && !$past(ddr_on) && $past(edge_hi)) |-> output_data_clock;
   endproperty
   a_sdr_edge: assert property (p_sdr_edge) else $error("SDR data on wrong clock edge");

   property p_ddr_toggle;
      @(posedge clk) disable iff (reset)
      (ce && fall_ev && st.word_phase && ddr_on && st.fsm == ST_RUN)
         |=> $changed(output_data_clock);
   endproperty
   a_ddr_toggle: assert property (p_ddr_toggle) else $error("DDR clock missed a word");

   property p_q_off;
      @(posedge clk) disable iff (reset)
      (ce && fall_ev && st.s2.qpd && st.fsm == ST_RUN)
         |=> (st.qhist[0] == 8'h00);
   endproperty
   a_q_off: assert property (p_q_off) else $error("Q converter sampled while off");

endmodule : aocp_core

// ==== test/aocp_rx_model.sv ====
// Purpose: Receiving logic that takes each output word with the forwarded clock.
// Assumes: A word and its launching clock edge leave the converter on one clk edge.
// Notes: Counts clock toggles and words that arrive without their proper edge.
`timescale 1ns/10ps
module aocp_rx_model (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Link from the converter.
   input wire aocp_pkg::aocp_bus_t data_bus,
   input wire logic output_data_clock,
   // Receiver set-up: single data rate and the edge that launches data.
   input wire logic sdr,
   input wire logic edge_sel,
   // Statistics.
   output int toggles,
   output int edge_errs
);
   import aocp_pkg::*;
   aocp_bus_t bus_reg;
   logic clk_reg;

   // A word is captured on the edge that launched it, so a word without an
   // edge, or on the wrong edge in single data rate, would be lost.
   always_ff @(posedge clk) begin
      bus_reg <= data_bus;
      clk_reg <= output_data_clock;
      if (reset) begin
         toggles <= 0;
         edge_errs <= 0;
      end else begin
         if (output_data_clock !== clk_reg) begin
            toggles <= toggles + 1;
         end
         if (data_bus !== bus_reg && (output_data_clock === clk_reg ||
               (sdr && output_data_clock !== edge_sel))) begin
            edge_errs <= edge_errs + 1;
         end
      end
   end
endmodule : aocp_rx_model

// ==== test/adc_output_clock_power_ctrl_tb_top.sv ====
// Purpose: Self-checking bench of the converter output clocking and power control.
// Assumes: Short counts 8, 16, 2 and 2; an 80 ns input clock built from clk.
// Notes: Each data pin carries its input-clock edge number, Q with bit 7 flipped, so latency reads off directly.
`timescale 1ns/10ps
module adc_output_clock_power_ctrl_tb_top;
   import aocp_pkg::*;
   localparam logic [31:0] zero32 = 32'h0000_0000;
   localparam logic [31:0] one32 = 32'h0000_0001;
   logic clk, reset, conv_clk, pd, qpd, trim_req, edge_sel, edge_float, swing, des, ext;
   logic avs_read, avs_write, avs_waitrequest, data_oe, oclk, oor, drive_full, trim_run;
   logic data_valid, q_act, sdr_mode;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [7:0] i_in, q_in;
   aocp_bus_t data_bus;
   int hc, n, t0, e0, toggles, edge_errs, num_errors, samples_checked;

   aocp_core #(.PU_DELAY_CYC(16'h0008), .CAL_CYC(16'h0010), .TRIM_LOW_MIN(8'h02),
      .TRIM_HIGH_MIN(8'h02)) dut (
      .clk(clk), .reset(reset), .ce(1'b1), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .conv_clk(conv_clk), .i_in(i_in), .q_in(q_in), .power_down_pin(pd),
      .q_channel_power_down(qpd), .trim_request(trim_req), .output_edge_select(edge_sel),
      .output_edge_floating(edge_float), .output_swing_select(swing), .des_select(des),
      .ext_control_enable(ext), .data_bus(data_bus), .data_oe(data_oe),
      .output_data_clock(oclk), .out_of_range_flag(oor), .output_drive_full(drive_full),
      .trim_running(trim_run), .data_valid(data_valid), .q_converter_active(q_act));

   aocp_rx_model rx (
      .clk(clk), .reset(reset), .data_bus(data_bus), .output_data_clock(oclk),
      .sdr(sdr_mode), .edge_sel(edge_sel), .toggles(toggles), .edge_errs(edge_errs));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Pins change midway between input-clock edges so the sampled value is never in doubt.
   initial begin
      hc = 0;
      conv_clk = 1'b0;
      i_in = 8'h00;
      q_in = 8'h80;
      forever begin
         repeat (3) @(posedge clk);
         i_in <= 8'(hc + 1);
         q_in <= 8'(hc + 1) ^ 8'h80;
         repeat (2) @(posedge clk);
         conv_clk <= ~conv_clk;
         hc <= hc + 1;
      end
   end

   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic av(input logic rnw, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= rnw;
      avs_write <= !rnw;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : av

   task automatic wait_for(input logic use_valid, input logic v, input int lim);
      n = 0;
      while ((use_valid ? data_valid : trim_run) !== v && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_for

   task automatic wait_word();
      aocp_bus_t old;
      old = data_bus;
      n = 0;
      while (data_bus === old && n < 40) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_word

   // Falls carry even edge numbers; the word on the bus belongs to the last fall.
   task automatic chk_bus(input logic d, input logic sq, input logic qon);
      int h;
      aocp_bus_t e;
      wait_word();
      h = hc - hc % 2;
      e.i_cur = 8'(h - 26) ^ {sq, 7'h00};
      e.i_del = 8'(h - 28) ^ {sq, 7'h00};
      e.q_cur = 8'(h - 26 - int'(d)) ^ {sq | !d, 7'h00};
      e.q_del = 8'(h - 28 - int'(d)) ^ {sq | !d, 7'h00};
      if (qon) begin
         chk(data_bus, e);
      end else begin
         chk(32'({data_bus.i_del, data_bus.i_cur}), 32'({e.i_del, e.i_cur}));
      end
   endtask : chk_bus

   task automatic measure(input int exp_t);
      wait_word();
      wait_word();
      @(posedge clk);
      t0 = toggles;
      e0 = edge_errs;
      repeat (10) wait_word();
      @(posedge clk);
      chk(32'(toggles - t0), 32'(exp_t));
      chk(32'(edge_errs - e0), zero32);
   endtask : measure

   task automatic trim_pulse(input logic cal_exp);
      trim_req <= 1'b0;
      repeat (40) @(posedge clk);
      trim_req <= 1'b1;
      wait_for(1'b0, 1'b1, 80);
      chk(32'(trim_run), 32'(cal_exp));
   endtask : trim_pulse

   initial begin
      #200000;
      num_errors++;
      summarize();
   end

   initial begin
      reset = 1'b1;
      pd = 1'b1;
      qpd = 1'b0;
      trim_req = 1'b1;
      edge_sel = 1'b1;
      edge_float = 1'b1;
      swing = 1'b1;
      des = 1'b0;
      ext = 1'b0;
      sdr_mode = 1'b0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_address = 4'h0;
      avs_writedata = zero32;
      num_errors = 0;
      samples_checked = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      av(1'b1, 4'h0, zero32);
      chk(rd, 32'h0000_006C);
      av(1'b0, 4'hC, 32'hFFFF_FFFF);
      av(1'b1, 4'hC, zero32);
      chk(rd, zero32);
      repeat (300) @(posedge clk);
      chk(32'(trim_run), zero32);
      pd <= 1'b0;
      wait_for(1'b0, 1'b1, 300);
      wait_for(1'b0, 1'b0, 400);
      chk(32'(n >= 150 && n <= 180), one32);
      wait_for(1'b1, 1'b1, 400);
      chk_bus(1'b0, 1'b0, 1'b1);
      measure(10);
      edge_float <= 1'b0;
      sdr_mode <= 1'b1;
      measure(20);
      edge_sel <= 1'b0;
      measure(20);
      swing <= 1'b0;
      repeat (5) @(posedge clk);
      chk(32'(drive_full), zero32);
      swing <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'(drive_full), one32);
      qpd <= 1'b1;
      repeat (5) @(posedge clk);
      chk(32'(q_act), zero32);
      chk_bus(1'b0, 1'b0, 1'b0);
      trim_pulse(1'b1);
      wait_for(1'b0, 1'b0, 300);
      av(1'b1, 4'h4, zero32);
      chk(32'(rd[5:4]), 32'h0000_0003);
      qpd <= 1'b0;
      repeat (5) @(posedge clk);
      av(1'b1, 4'h4, zero32);
      chk(32'({q_act, rd[5:4]}), 32'h0000_0005);
      trim_pulse(1'b1);
      wait_for(1'b0, 1'b0, 300);
      av(1'b1, 4'h4, zero32);
      chk(32'(rd[5:4]), zero32);
      wait_for(1'b1, 1'b1, 400);
      av(1'b1, 4'h8, zero32);
      chk(rd, zero32);
      des <= 1'b1;
      repeat (20) wait_word();
      chk_bus(1'b1, 1'b0, 1'b1);
      av(1'b1, 4'h8, zero32);
      chk(32'(rd[5:0] != 6'h00), one32);
      des <= 1'b0;
      trim_pulse(1'b1);
      pd <= 1'b1;
      repeat (60) @(posedge clk);
      av(1'b1, 4'h4, zero32);
      chk(32'({rd[2], rd[0], trim_run}), 32'h0000_0007);
      wait_for(1'b0, 1'b0, 300);
      repeat (20) @(posedge clk);
      chk(32'({data_oe, oclk, oor, data_valid}), zero32);
      trim_pulse(1'b0);
      pd <= 1'b0;
      n = 0;
      t0 = 0;
      while (data_valid !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
         t0 += int'(trim_run);
      end
      chk(32'(t0), zero32);
      chk(32'(n >= 130 && n <= 230), one32);
      ext <= 1'b1;
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      wait_for(1'b1, 1'b1, 800);
      av(1'b0, 4'h0, 32'hFFFF_FF6F);
      av(1'b1, 4'h0, zero32);
      chk(rd, 32'h0000_006F);
      sdr_mode <= 1'b0;
      measure(10);
      chk_bus(1'b1, 1'b1, 1'b1);
      av(1'b0, 4'h0, 32'h0000_004F);
      repeat (5) @(posedge clk);
      chk(32'(drive_full), zero32);
      summarize();
   end
endmodule : adc_output_clock_power_ctrl_tb_top
